// >>> fcsas_defs.vh
// constants for the flash size, address and signature register block
//
// Function
// R1: bit 20 reports debug port lockout
// R2: bit 19 reports main array key lock
// R3: bits 18:17 encode available sram size
// R4: bits 15:0 hold last usable word address
// R5: top bus word address follows array size
// R6: address bits 15:6 select page and row
// R7: address bits 5:0 select word in row
// R8: array is 128 pages, 8 rows, 64 words
// R9: software loads address in component format
// R10: signature presets to all ones on start
// R11: every word read advances the signature
// R12: signature final once command finished flag set
// R13: protected page segments refuse word writes
// R14: at most four protection segments exist
// R15: command finished flag set, cleared by one
// R16: read match flag only if all words match
// R17: lfsr polynomial and direction are parameters
// R18: size fields sampled from straps after reset
`ifndef FCSAS_DEFS_VH
`define FCSAS_DEFS_VH

// register offsets (byte addresses)
`define FCSAS_OFS_CMD          8'h00
`define FCSAS_OFS_FLAGS        8'h04
`define FCSAS_OFS_SIZE         8'h14
`define FCSAS_OFS_ADDR         8'h18
`define FCSAS_OFS_SIG          8'h24
`define FCSAS_OFS_TOP_BUS      8'h28
`define FCSAS_OFS_PROT01       8'h34
`define FCSAS_OFS_PROT23       8'h38
`define FCSAS_OFS_FIRST_DATA_WORD        8'h40

// size register field positions
`define FCSAS_SIZE_DBG_BIT     20
`define FCSAS_SIZE_KEY_BIT     19
`define FCSAS_SIZE_RAM_HI      18
`define FCSAS_SIZE_RAM_LO      17
`define FCSAS_SIZE_LAST_HI     15

// address register fields
`define FCSAS_ROW_SEL_HI       15
`define FCSAS_ROW_SEL_LO       6
`define FCSAS_PAGE_HI          15
`define FCSAS_PAGE_LO          9
`define FCSAS_WORD_HI          5

// flags register bit positions
`define FCSAS_FLG_DONE         0
`define FCSAS_FLG_MATCH        1
`define FCSAS_FLG_BUSY_ERR     2
`define FCSAS_FLG_ILL_CMD      3
`define FCSAS_FLG_PROT_ERR     4
`define FCSAS_FLG_BUSY         8

// segment field positions
`define FCSAS_SEG_OFS_HI       14
`define FCSAS_SEG_OFS_LO       8
`define FCSAS_SEG_LEN_HI       6
`define FCSAS_NUM_SEGS         4

// command opcodes
`define FCSAS_OP_FULL_READ     8'h01
`define FCSAS_OP_WORD_WRITE    8'h02

// reset values
`define FCSAS_SIG_RESET        32'hffffffff
`define FCSAS_FIRST_DATA_WORD_RESET      32'hffffffff
`define FCSAS_ADDR_RESET       16'h0000
`define FCSAS_PROT_RESET       32'h00000000

// bus mapping of the array: base is the bus address of the first array word
`define FCSAS_BUS_BASE         32'h10040000

// signature lfsr defaults
`define FCSAS_LFSR_POLY        32'h04c11db7
`define FCSAS_LFSR_LEFT        1'b1

`endif

// >>> fcsas_sig_step.v
// one signature lfsr step that folds in a single array word
`timescale 1ns/1ns
`default_nettype none

module fcsas_sig_step #(
  parameter [31:0] POLY       = 32'h04c11db7, // feedback taps
  parameter        SHIFT_LEFT = 1'b1          // shift direction
) (
  input  wire [31:0] state_in,  // current signature
  input  wire [31:0] word_in,   // word read from the array
  output reg  [31:0] state_out  // signature after one step
);

  // one shift, feedback xor, then fold the data word in [R17]
  always @* begin
    if (SHIFT_LEFT) begin
      state_out = {state_in[30:0], 1'b0} ^
                  (state_in[31] ? POLY : 32'h00000000) ^ word_in;
    end else begin
      state_out = {1'b0, state_in[31:1]} ^
                  (state_in[0] ? POLY : 32'h00000000) ^ word_in;
    end
  end

endmodule

`default_nettype wire

// >>> fcsas_ctrl.v
// flash size, address, signature and write-protect register block
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "fcsas_defs.vh"

module fcsas_ctrl #(
  parameter [31:0] LFSR_POLY  = `FCSAS_LFSR_POLY, // signature taps
  parameter        LFSR_LEFT  = `FCSAS_LFSR_LEFT  // signature direction
) (
  input  wire        core_clk_in,        // 250 MHz core clock
  input  wire        nrst_in,            // async reset, active low
  // register port
  input  wire [7:0]  reg_addr_in,        // byte address
  input  wire [31:0] reg_wdata_in,       // write data
  input  wire        reg_wr_in,          // write strobe
  input  wire        reg_rd_in,          // read strobe
  output reg  [31:0] reg_rdata_out,      // read data, next cycle
  // static device configuration straps
  input  wire        cfg_debug_lock_in,  // debug port locked
  input  wire        cfg_key_lock_in,    // main array key locked
  input  wire [1:0]  cfg_ram_size_in,    // ram size code
  input  wire [15:0] cfg_last_word_in,   // last usable word address
  // flash array port
  output reg         arr_rd_req_out,     // read request, held to ack
  output reg         arr_wr_req_out,     // write request, held to ack
  output reg  [15:0] arr_addr_out,       // component format address
  output reg  [31:0] arr_wdata_out,      // word to program
  input  wire [31:0] arr_rdata_in,       // read word, valid with ack
  input  wire        arr_ack_in,         // one-cycle completion
  output reg         busy_out            // command in progress
);

  // sequencer states
  localparam [1:0] ST_IDLE   = 2'b00;  // waiting for a command
  localparam [1:0] ST_READ   = 2'b01;  // full array read running
  localparam [1:0] ST_WRITE  = 2'b10;  // single word program running
  localparam [1:0] ST_FINISH = 2'b11;  // raise the finished flag

  // is page inside one segment; end past the array clamps itself
  // because the page index can never exceed the last page
  function seg_hit;
    input [15:0] seg;
    input [6:0]  page;
    reg   [7:0]  seg_end;
    begin
      seg_end = {1'b0, seg[`FCSAS_SEG_OFS_HI:`FCSAS_SEG_OFS_LO]} +
                {1'b0, seg[`FCSAS_SEG_LEN_HI:0]};
      seg_hit = (seg[`FCSAS_SEG_LEN_HI:0] != 7'h00) &&
                (page >= seg[`FCSAS_SEG_OFS_HI:`FCSAS_SEG_OFS_LO]) &&
                ({1'b0, page} < seg_end);
    end
  endfunction

  // configuration capture
  reg        cfg_taken_ff;       // straps captured once
  reg        dbg_lock_ff;        // debug lockout status
  reg        key_lock_ff;        // main array key lock
  reg [1:0]  ram_size_ff;        // ram size code
  reg [15:0] last_word_ff;       // last usable word address
  reg [31:0] top_bus_ff;         // highest usable bus word address

  // software registers
  reg [15:0] addr_ff;            // row select and word in row
  reg [31:0] first_data_word_ff;           // program word and compare value
  reg [31:0] prot01_ff;          // segments 0 and 1
  reg [31:0] prot23_ff;          // segments 2 and 3
  reg [31:0] sig_ff;             // read signature

  // sequencer
  reg [1:0]  state_ff;           // current state
  reg [15:0] rd_ptr_ff;          // full read word pointer
  reg        all_match_ff;       // every word so far matched first_data_word

  // sticky flags
  reg        done_flag_ff;       // command finished
  reg        match_flag_ff;      // full read matched
  reg        busy_err_ff;        // command while busy
  reg        ill_cmd_ff;         // unknown opcode
  reg        prot_err_ff;        // write hit a protected page

  // decoded strobes
  wire       wr_cmd    = reg_wr_in && (reg_addr_in == `FCSAS_OFS_CMD);
  wire       wr_flags  = reg_wr_in && (reg_addr_in == `FCSAS_OFS_FLAGS);
  wire [7:0] opcode    = reg_wdata_in[7:0];
  wire       idle      = (state_ff == ST_IDLE);
  wire       start_rd  = wr_cmd && idle &&
                         (opcode == `FCSAS_OP_FULL_READ);
  wire       start_wr  = wr_cmd && idle &&
                         (opcode == `FCSAS_OP_WORD_WRITE);
  wire       bad_op    = wr_cmd && (opcode != `FCSAS_OP_FULL_READ) &&
                         (opcode != `FCSAS_OP_WORD_WRITE);

  // page of the target word, upper part of the row select [R6]
  wire [6:0] tgt_page  = addr_ff[`FCSAS_PAGE_HI:`FCSAS_PAGE_LO];

  // a page is guarded if any of the four segments covers it [R13] [R14]
  wire       tgt_prot  = seg_hit(prot01_ff[15:0],  tgt_page) ||
                         seg_hit(prot01_ff[31:16], tgt_page) ||
                         seg_hit(prot23_ff[15:0],  tgt_page) ||
                         seg_hit(prot23_ff[31:16], tgt_page);

  // the signature step for the word now returning
  wire [31:0] sig_step;           // signature after folding arr_rdata_in

  fcsas_sig_step #(
    .POLY       (LFSR_POLY),
    .SHIFT_LEFT (LFSR_LEFT)
  ) u_sig_step (
    .state_in  (sig_ff),
    .word_in   (arr_rdata_in),
    .state_out (sig_step)
  );

  wire       rd_ack    = (state_ff == ST_READ) && arr_ack_in;
  wire       rd_last   = (rd_ptr_ff == last_word_ff);

  // straps are static; capture them on the first edge after release
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_taken_ff <= 1'b0;
      dbg_lock_ff  <= 1'b0;
      key_lock_ff  <= 1'b0;
      ram_size_ff  <= 2'b00;
      last_word_ff <= 16'h0000;
      top_bus_ff   <= 32'h00000000;
    end else if (!cfg_taken_ff) begin
      cfg_taken_ff <= 1'b1;
      dbg_lock_ff  <= cfg_debug_lock_in;                        // [R1] [R18]
      key_lock_ff  <= cfg_key_lock_in;                          // [R2] [R18]
      ram_size_ff  <= cfg_ram_size_in;                          // [R3] [R18]
      last_word_ff <= cfg_last_word_in;                         // [R4] [R18]
      // word index scaled to bytes on top of the bus base    // [R5]
      top_bus_ff   <= `FCSAS_BUS_BASE +
                      {14'h0000, cfg_last_word_in, 2'b00};
    end
  end

  // software written registers
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr_ff   <= `FCSAS_ADDR_RESET;
      first_data_word_ff  <= `FCSAS_FIRST_DATA_WORD_RESET;
      prot01_ff <= `FCSAS_PROT_RESET;
      prot23_ff <= `FCSAS_PROT_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        // component format taken as is, upper bits dropped [R9]
        `FCSAS_OFS_ADDR:   addr_ff   <= reg_wdata_in[15:0];
        `FCSAS_OFS_FIRST_DATA_WORD:  first_data_word_ff  <= reg_wdata_in;
        `FCSAS_OFS_PROT01: prot01_ff <= reg_wdata_in;
        `FCSAS_OFS_PROT23: prot23_ff <= reg_wdata_in;
        default: begin
          addr_ff <= addr_ff;  // read-only or unmapped: no effect
        end
      endcase
    end
  end

  // command sequencer
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_ff       <= ST_IDLE;
      rd_ptr_ff      <= 16'h0000;
      all_match_ff   <= 1'b0;
      sig_ff         <= `FCSAS_SIG_RESET;                       // [R10]
      arr_rd_req_out <= 1'b0;
      arr_wr_req_out <= 1'b0;
      arr_addr_out   <= 16'h0000;
      arr_wdata_out  <= 32'h00000000;
      busy_out       <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_rd) begin
            // preset on the command write itself              // [R10]
            sig_ff         <= `FCSAS_SIG_RESET;
            all_match_ff   <= 1'b1;
            rd_ptr_ff      <= 16'h0000;
            arr_addr_out   <= 16'h0000;
            arr_rd_req_out <= 1'b1;
            busy_out       <= 1'b1;
            state_ff       <= ST_READ;
          end else if (start_wr) begin
            busy_out <= 1'b1;
            if (tgt_prot) begin
              // guarded page: no array access at all           // [R13]
              state_ff <= ST_FINISH;
            end else begin
              arr_addr_out   <= addr_ff;                        // [R6] [R7]
              arr_wdata_out  <= first_data_word_ff;
              arr_wr_req_out <= 1'b1;
              state_ff       <= ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (arr_ack_in) begin
            // one lfsr step per returned word                 // [R11] [R17]
            sig_ff <= sig_step;
            if (arr_rdata_in != first_data_word_ff) begin
              all_match_ff <= 1'b0;                             // [R16]
            end
            if (rd_last) begin
              arr_rd_req_out <= 1'b0;
              state_ff       <= ST_FINISH;
            end else begin
              // walk each word from 0 up to the last usable word          // [R8]
              rd_ptr_ff    <= rd_ptr_ff + 16'h0001;
              arr_addr_out <= rd_ptr_ff + 16'h0001;
            end
          end
        end
        ST_WRITE: begin
          if (arr_ack_in) begin
            arr_wr_req_out <= 1'b0;
            state_ff       <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          // signature is already final and stays until next start [R12]
          busy_out <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // sticky flags: a set in the same cycle as a write-one clear wins
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      done_flag_ff  <= 1'b0;
      match_flag_ff <= 1'b0;
      busy_err_ff   <= 1'b0;
      ill_cmd_ff    <= 1'b0;
      prot_err_ff   <= 1'b0;
    end else begin
      // finished flag, cleared by writing one                 // [R15]
      if (state_ff == ST_FINISH) begin
        done_flag_ff <= 1'b1;                                   // [R12]
      end else if (wr_flags && reg_wdata_in[`FCSAS_FLG_DONE]) begin
        done_flag_ff <= 1'b0;
      end
      // match only at the end of a full read where all matched [R16]
      if (rd_ack && rd_last &&
          all_match_ff && (arr_rdata_in == first_data_word_ff)) begin
        match_flag_ff <= 1'b1;
      end else if (wr_flags && reg_wdata_in[`FCSAS_FLG_MATCH]) begin
        match_flag_ff <= 1'b0;
      end
      // command arriving while a command runs is dropped
      if (wr_cmd && !idle && !bad_op) begin
        busy_err_ff <= 1'b1;
      end else if (wr_flags && reg_wdata_in[`FCSAS_FLG_BUSY_ERR]) begin
        busy_err_ff <= 1'b0;
      end
      // unknown opcode is never started
      if (bad_op) begin
        ill_cmd_ff <= 1'b1;
      end else if (wr_flags && reg_wdata_in[`FCSAS_FLG_ILL_CMD]) begin
        ill_cmd_ff <= 1'b0;
      end
      // program refused by a segment                            [R13]
      if (start_wr && tgt_prot) begin
        prot_err_ff <= 1'b1;
      end else if (wr_flags && reg_wdata_in[`FCSAS_FLG_PROT_ERR]) begin
        prot_err_ff <= 1'b0;
      end
    end
  end

  // read mux: data stand in the cycle after the strobe only
  always @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `FCSAS_OFS_FLAGS: begin
          reg_rdata_out <= {23'h000000, busy_out, 3'b000,
                            prot_err_ff, ill_cmd_ff, busy_err_ff,
                            match_flag_ff, done_flag_ff};
        end
        `FCSAS_OFS_SIZE: begin
          // reserved bits 31:21 and 16 read zero       // [R1] [R2] [R3] [R4]
          reg_rdata_out <= {11'h000, dbg_lock_ff, key_lock_ff,
                            ram_size_ff, 1'b0, last_word_ff};
        end
        `FCSAS_OFS_ADDR:    reg_rdata_out <= {16'h0000, addr_ff};
        `FCSAS_OFS_SIG:     reg_rdata_out <= sig_ff;            // [R12]
        `FCSAS_OFS_TOP_BUS: reg_rdata_out <= top_bus_ff;        // [R5]
        `FCSAS_OFS_PROT01:  reg_rdata_out <= prot01_ff;
        `FCSAS_OFS_PROT23:  reg_rdata_out <= prot23_ff;
        `FCSAS_OFS_FIRST_DATA_WORD:   reg_rdata_out <= first_data_word_ff;
        default:            reg_rdata_out <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

endmodule

`default_nettype wire

// >>> fcsas_ctrl_assertions.sv
// port checker for the size, address and signature block
`timescale 1ns/1ns
`default_nettype none
module fcsas_ctrl_chk (
  input wire logic        core_clk_in,
  input wire logic        nrst_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic        cfg_debug_lock_in,
  input wire logic        cfg_key_lock_in,
  input wire logic [1:0]  cfg_ram_size_in,
  input wire logic [15:0] cfg_last_word_in,
  input wire logic        arr_rd_req_out,
  input wire logic        arr_wr_req_out,
  input wire logic [15:0] arr_addr_out,
  input wire logic [31:0] arr_wdata_out,
  input wire logic [31:0] arr_rdata_in,
  input wire logic        arr_ack_in,
  input wire logic        busy_out
);
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);
  // a read word completes; straps are static so compare them live
  wire logic ack_rd = arr_rd_req_out && arr_ack_in;
  wire logic at_last = arr_addr_out == cfg_last_word_in;
  // full read accepted only while idle
  wire logic go_rd = reg_wr_in && reg_addr_in == 8'h00 &&
                     reg_wdata_in[7:0] == 8'h01 && !busy_out;
  AST_SIZE_FIELDS: assert property (
    $past(reg_rd_in && reg_addr_in == 8'h14) |-> reg_rdata_out ==
    {11'h000, cfg_debug_lock_in, cfg_key_lock_in, cfg_ram_size_in, 1'b0,
    cfg_last_word_in}) else $error("size register fields wrong");
  AST_TOP_BUS: assert property (
    $past(reg_rd_in && reg_addr_in == 8'h28)
    |-> reg_rdata_out == 32'h10040000 + {14'h0, cfg_last_word_in, 2'h0})
    else $error("top bus word address wrong");
  AST_START: assert property (
    go_rd |=> busy_out && arr_rd_req_out && arr_addr_out == 16'h0000)
    else $error("full read did not start");
  AST_SIG_PRESET: assert property (
    go_rd ##1 reg_rd_in && reg_addr_in == 8'h24 |=>
    reg_rdata_out == 32'hffffffff) else $error("signature not preset");
  AST_STEP: assert property (
    ack_rd && !at_last |=> arr_rd_req_out &&
    arr_addr_out == $past(arr_addr_out) + 16'h0001)
    else $error("read address did not advance by one");
  AST_HOLD: assert property (
    arr_rd_req_out && !arr_ack_in |=>
    arr_rd_req_out && $stable(arr_addr_out))
    else $error("read request dropped before answer");
  AST_LAST_DROP: assert property (
    ack_rd && at_last |=> !arr_rd_req_out && busy_out ##1 !busy_out)
    else $error("full read did not finish two cycles after last word");
  AST_WR_DONE: assert property (
    arr_wr_req_out && arr_ack_in |=>
    !arr_wr_req_out && busy_out ##1 !busy_out)
    else $error("word write did not finish");
  AST_WR_HOLD: assert property (
    arr_wr_req_out && !arr_ack_in |=>
    arr_wr_req_out && $stable(arr_addr_out) && $stable(arr_wdata_out))
    else $error("write request changed before answer");
endmodule
bind fcsas_ctrl fcsas_ctrl_chk i_chk (.core_clk_in, .nrst_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cfg_debug_lock_in,
  .cfg_key_lock_in, .cfg_ram_size_in, .cfg_last_word_in, .arr_rd_req_out,
  .arr_wr_req_out, .arr_addr_out, .arr_wdata_out, .arr_rdata_in,
  .arr_ack_in, .busy_out);
`default_nettype wire

// >>> fcsas_array_model.sv
// behavioural flash array answering read and program requests
`timescale 1ns/1ns
`default_nettype none
module fcsas_array_model (
  input  wire logic        clk_in,
  input  wire logic        rd_req_in,
  input  wire logic        wr_req_in,
  input  wire logic [15:0] addr_in,    // page, row, word
  input  wire logic [31:0] wdata_in,
  input  wire logic        same_in,    // every word equals fill
  input  wire logic [31:0] fill_in,
  output var  logic [31:0] rdata_out,
  output var  logic        ack_out,
  output var  logic [15:0] wr_addr_out,
  output var  logic [31:0] wr_data_out,
  output var  logic [7:0]  wr_cnt_out
);
  logic [1:0] wait_ff = 2'h0;          // random answer delay
  initial begin
    rdata_out = 32'h5a5aa5a5;
    ack_out = 1'b0;
    wr_addr_out = 16'h0000;
    wr_data_out = 32'h0;
    wr_cnt_out = 8'h00;
  end
  // one ack per word, prompt or up to two cycles late
  always @(posedge clk_in) begin
    if (ack_out) begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;         // released bus must not hold the word
    end else if ((rd_req_in || wr_req_in) && wait_ff != 2'h0) begin
      wait_ff <= wait_ff - 2'h1;
    end else if (rd_req_in) begin
      ack_out <= 1'b1;
      rdata_out <= same_in ? fill_in : fill_in ^ {addr_in, addr_in};
      wait_ff <= 2'($urandom % 3);
    end else if (wr_req_in) begin
      ack_out <= 1'b1;
      wr_addr_out <= addr_in;
      wr_data_out <= wdata_in;
      wr_cnt_out <= wr_cnt_out + 8'h01;
      wait_ff <= 2'($urandom % 3);
    end
  end
endmodule
`default_nettype wire

// >>> fcsas_ctrl_tb.sv
// self-checking bench for the size, address and signature block
`timescale 1ns/1ns
`default_nettype none
`include "fcsas_defs.vh"
`define CHK(nm, e, g) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    fails++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); \
  end \
end
module fcsas_ctrl_tb;
  logic        core_clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        cfg_debug_lock_in = 1'b0;
  logic        cfg_key_lock_in = 1'b0;
  logic [1:0]  cfg_ram_size_in = 2'h0;
  logic [15:0] cfg_last_word_in = 16'h7fff;
  logic        same = 1'b1;
  logic [31:0] fill = 32'h0;
  wire  [31:0] reg_rdata_out, arr_wdata_out, arr_rdata_in, m_wdata;
  wire         arr_rd_req_out, arr_wr_req_out, arr_ack_in, busy_out;
  wire  [15:0] arr_addr_out, m_waddr;
  wire  [7:0]  m_wcnt;
  int          fails = 0;
  int          tests_run = 0;
  logic        rd_q = 1'b0;            // read answer due this cycle
  logic [31:0] exp_q[$], e_v, d0, s, ba;
  string       nm_q[$], n_v;
  logic [15:0] areg;
  logic [15:0] lasts[3] = '{16'h7fff, 16'hbfff, 16'hffff};
  logic [31:0] tops[3] = '{32'h1005fffc, 32'h1006fffc, 32'h1007fffc};
  logic [6:0]  pages[6] = '{7'd11, 7'd40, 7'd127, 7'd72, 7'd73, 7'd12};
  localparam logic [15:0] LAST = 16'h0007; // short array keeps runs brief
  fcsas_ctrl i_dut (.core_clk_in, .nrst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cfg_debug_lock_in,
    .cfg_key_lock_in, .cfg_ram_size_in, .cfg_last_word_in, .arr_rd_req_out,
    .arr_wr_req_out, .arr_addr_out, .arr_wdata_out, .arr_rdata_in,
    .arr_ack_in, .busy_out);
  fcsas_array_model i_arr (.clk_in(core_clk_in), .rd_req_in(arr_rd_req_out),
    .wr_req_in(arr_wr_req_out), .addr_in(arr_addr_out),
    .wdata_in(arr_wdata_out), .same_in(same), .fill_in(fill),
    .rdata_out(arr_rdata_in), .ack_out(arr_ack_in), .wr_addr_out(m_waddr),
    .wr_data_out(m_wdata), .wr_cnt_out(m_wcnt));
  always #2 core_clk_in = ~core_clk_in;
  // read data stand one cycle only, so compare at the following edge
  always @(posedge core_clk_in) begin
    if (rd_q) begin
      n_v = nm_q.pop_front();
      e_v = exp_q.pop_front();
      `CHK(n_v, e_v, reg_rdata_out)
    end
    rd_q <= reg_rd_in;
  end
  function automatic logic [31:0] step(input logic [31:0] st, w);
    return {st[30:0], 1'b0} ^ (st[31] ? `FCSAS_LFSR_POLY : 32'h0) ^ w;
  endfunction
  // one bus cycle; strobes stay up so calls may run back to back
  task automatic bus(input logic w, r, input logic [7:0] a,
                     input logic [31:0] d);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge core_clk_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(input string n, input logic [7:0] a,
                    input logic [31:0] e);
    exp_q.push_back(e);
    nm_q.push_back(n);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, reg_addr_in, 32'h0);
  endtask
  // two idle edges first: busy is seen before each edge's update
  task automatic settle();
    idle(2);
    for (int i = 0; i < 200 && busy_out !== 1'b0; i++) idle(1);
    `CHK("busy", 1'b0, busy_out)
    idle(1);
  endtask
  task automatic do_reset(input logic [15:0] last);
    nrst_in <= 1'b0;
    cfg_last_word_in <= last;
    cfg_debug_lock_in <= 1'($urandom);
    cfg_key_lock_in <= 1'($urandom);
    cfg_ram_size_in <= 2'($urandom);
    idle(2);
    nrst_in <= 1'b1;
    idle(2);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #40000; // ten thousand cycles, far above the few hundred needed
    fails++;
    conclude();
  end
  initial begin
    void'($urandom(6999));
    // size, top address and reset values for each array size
    foreach (lasts[i]) begin
      do_reset(lasts[i]);
      s = {11'h0, cfg_debug_lock_in, cfg_key_lock_in, cfg_ram_size_in,
           1'b0, lasts[i]};
      rd("size", 8'h14, s);
      rd("top", 8'h28, tops[i]);
      rd("addr", 8'h18, 32'h0);
      rd("sig", 8'h24, 32'hffffffff);
      rd("hole", 8'h7c, 32'h0);
      wr(8'h14, 32'h0);
      rd("size_ro", 8'h14, s);
      idle(1);
    end
    $display("test size done");
    // bus address to component format, then one word write
    do_reset(LAST);
    ba = 32'h10040000 | (32'($urandom) & 32'h0003fffc);
    areg = {ba[17:8], ba[7:2]};
    d0 = 32'($urandom);
    wr(8'h18, {16'hffff, areg});
    rd("addr", 8'h18, {16'h0, areg});
    wr(8'h40, d0);
    wr(8'h00, 32'h2);
    settle();
    `CHK("waddr", areg, m_waddr)
    `CHK("wdata", d0, m_wdata)
    rd("flags", 8'h04, 32'h1);
    wr(8'h04, 32'h1f);
    rd("clear", 8'h04, 32'h0);
    idle(1);
    $display("test address done");
    // full reads: all words equal, then all but the first differ
    for (int m = 0; m < 2; m++) begin
      same <= m == 0;
      fill <= d0;
      s = 32'hffffffff;
      for (int a = 0; a <= LAST; a++)
        s = step(s, m == 0 ? d0 : d0 ^ {a[15:0], a[15:0]});
      wr(8'h00, 32'h1);
      rd("preset", 8'h24, 32'hffffffff);
      wr(8'h00, 32'h1);
      rd("busy", 8'h04, 32'h104);
      settle();
      rd("sig", 8'h24, s);
      rd("flags", 8'h04, m == 0 ? 32'h7 : 32'h5);
      wr(8'h04, 32'h1f);
    end
    idle(1);
    $display("test signature done");
    // four segments, one clamped at the top page
    wr(8'h34, 32'h28010a02);
    wr(8'h38, 32'h46037e05);
    rd("seg01", 8'h34, 32'h28010a02);
    rd("seg23", 8'h38, 32'h46037e05);
    foreach (pages[i]) begin
      wr(8'h18, {16'h0, pages[i], 9'h000});
      wr(8'h00, 32'h2);
      settle();
      rd("prot", 8'h04, i < 4 ? 32'h11 : 32'h01);
      wr(8'h04, 32'h1f);
    end
    // unknown opcode: flagged, never started, no array write
    wr(8'h00, 32'h7);
    rd("illegal", 8'h04, 32'h8);
    idle(3);
    `CHK("writes", 8'h03, m_wcnt)
    $display("test protect done");
    conclude();
  end
endmodule
`default_nettype wire
